//--- shared/elc_pkg.sv
// constants and types for the edge line controller
// Notes on behaviour
// R01: selected edge with mask sets pending, raises request
// R02: pending clears only by writing one
// R03: event-masked edge gives pulse, no pending
// R04: event pulse wakes core from wait
// R05: soft trigger zero-to-one with mask sets pending
// R06: soft trigger bit clears with its pending
// R07: interrupt mask at 0x00, bits 17:0
// R08: event mask at 0x04, one per line
// R09: rising select at 0x08 enables rising detect
// R10: falling select at 0x0C enables falling detect
// R11: both selects trigger on either edge
// R12: edge during select write sets no pending
// R13: line drivers must stay glitch free
// R14: bits 31:18 reserved, read as zero
// R15: master uses full word accesses only
// R16: mask, trigger, soft registers reset to zero
// R17: line 16 voltage detector, 17 clock alarm
// R18: lines 0-15 from externally selected pins
// R19: every line independently configurable
// R20: pending at 0x14, write one clears
// R21: sync edge detect, request is pending and mask
// R22: event pulse lasts exactly one cycle
package elc_pkg;
	localparam int          ELC_LINES          = 18;
	localparam logic [7:0]  ELC_OFS_IMASK      = 8'h00;
	localparam logic [7:0]  ELC_OFS_EMASK      = 8'h04;
	localparam logic [7:0]  ELC_OFS_RISE       = 8'h08;
	localparam logic [7:0]  ELC_OFS_FALL       = 8'h0C;
	localparam logic [7:0]  ELC_OFS_SOFT       = 8'h10;
	localparam logic [7:0]  ELC_OFS_PEND       = 8'h14;
	localparam logic [17:0] ELC_RST_ZERO       = 18'h00000;
	localparam logic [31:0] ELC_RDATA_ZERO     = 32'h00000000;
	localparam int          ELC_GPIO_LINES     = 16;
	localparam int          ELC_LINE_VDET      = 16;
	localparam int          ELC_LINE_ALARM     = 17;

	typedef struct packed {
		logic [17:0] imask;
		logic [17:0] emask;
		logic [17:0] rise;
		logic [17:0] fall;
	} elc_cfg_t;
endpackage

//--- hdl/elc_top.sv
// edge line controller: edge detect, pending flags, event pulses, APB slave
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module elc_top (
	input  wire logic                       pclk,          // peripheral clock
	input  wire logic                       presetn,       // async reset, active low
	input  wire logic                       psel,          // apb select
	input  wire logic                       penable,       // apb access phase
	input  wire logic                       pwrite,        // apb direction
	input  wire logic [7:0]                 paddr,         // apb byte address
	input  wire logic [31:0]                pwdata,        // apb write data
	output logic      [31:0]                prdata,        // apb read data
	output logic                            pready,        // apb ready
	output logic                            pslverr,       // apb error
	input  wire logic [elc_pkg::ELC_GPIO_LINES-1:0] gpio_lines, // selected pin lines
	input  wire logic                       voltage_detector_output, // line 16 source
	input  wire logic                       rtc_alarm,     // line 17 source
	output logic      [elc_pkg::ELC_LINES-1:0] line_irq,   // per line interrupt request
	output logic                            wake_event     // one cycle event pulse
);
	import elc_pkg::*;

	elc_cfg_t               cfg_reg;
	logic [ELC_LINES-1:0]   soft_reg;
	logic [ELC_LINES-1:0]   pend_reg;
	logic [ELC_LINES-1:0]   sync1_reg;
	logic [ELC_LINES-1:0]   sync2_reg;
	logic [ELC_LINES-1:0]   prev_reg;
	logic [ELC_LINES-1:0]   lines_in;
	logic [ELC_LINES-1:0]   edge_hit;
	logic [ELC_LINES-1:0]   soft_hit;
	logic [ELC_LINES-1:0]   pend_clr;
	logic [ELC_LINES-1:0]   pend_next;
	logic [ELC_LINES-1:0]   wdat;
	logic [ELC_LINES-1:0]   rise_blk;
	logic [ELC_LINES-1:0]   fall_blk;
	logic                   wr_en;
	logic                   wr_imask;
	logic                   wr_emask;
	logic                   wr_rise;
	logic                   wr_fall;
	logic                   wr_soft;
	logic                   wr_pend;
	logic                   addr_ok;

	assign lines_in = {rtc_alarm, voltage_detector_output, gpio_lines}; // [R17] [R18]

	// two-flop sync, then a third stage for edge compare
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= ELC_RST_ZERO;
			sync2_reg <= ELC_RST_ZERO;
			prev_reg  <= ELC_RST_ZERO;
		end else begin
			sync1_reg <= lines_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg; // [R21]
		end
	end

	// zero-wait slave: every access completes in its first access cycle
	assign wr_en    = psel && penable && pwrite;
	assign wdat     = pwdata[ELC_LINES-1:0]; // [R14] upper bits ignored
	assign wr_imask = wr_en && (paddr == ELC_OFS_IMASK);
	assign wr_emask = wr_en && (paddr == ELC_OFS_EMASK);
	assign wr_rise  = wr_en && (paddr == ELC_OFS_RISE);
	assign wr_fall  = wr_en && (paddr == ELC_OFS_FALL);
	assign wr_soft  = wr_en && (paddr == ELC_OFS_SOFT);
	assign wr_pend  = wr_en && (paddr == ELC_OFS_PEND);
	assign addr_ok  = (paddr == ELC_OFS_IMASK) || (paddr == ELC_OFS_EMASK) ||
			(paddr == ELC_OFS_RISE) || (paddr == ELC_OFS_FALL) ||
			(paddr == ELC_OFS_SOFT) || (paddr == ELC_OFS_PEND);

	// an edge landing on a write to its own select register is dropped
	assign rise_blk = wr_rise ? {ELC_LINES{1'b1}} : ELC_RST_ZERO; // [R12]
	assign fall_blk = wr_fall ? {ELC_LINES{1'b1}} : ELC_RST_ZERO; // [R12]

	genvar gi;
	generate
		for (gi = 0; gi < ELC_LINES; gi++) begin : g_line
			// either polarity counts when both selects are on
			assign edge_hit[gi] = (cfg_reg.rise[gi] && !rise_blk[gi] && sync2_reg[gi] && !prev_reg[gi]) ||
					(cfg_reg.fall[gi] && !fall_blk[gi] && !sync2_reg[gi] && prev_reg[gi]); // [R09] [R10] [R11] [R19]
			assign soft_hit[gi] = wr_soft && wdat[gi] && !soft_reg[gi]; // [R05]
			assign pend_clr[gi] = wr_pend && wdat[gi]; // [R02] [R20]
			// set beats clear when both land together
			assign pend_next[gi] = ((edge_hit[gi] || soft_hit[gi]) && cfg_reg.imask[gi]) ? 1'b1 :
					(pend_clr[gi] ? 1'b0 : pend_reg[gi]); // [R01] [R03] [R05]
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= '{imask: ELC_RST_ZERO, emask: ELC_RST_ZERO, rise: ELC_RST_ZERO, fall: ELC_RST_ZERO}; // [R16]
		end else begin
			if (wr_imask) begin
				cfg_reg.imask <= wdat; // [R07]
			end
			if (wr_emask) begin
				cfg_reg.emask <= wdat; // [R08]
			end
			if (wr_rise) begin
				cfg_reg.rise <= wdat; // [R09]
			end
			if (wr_fall) begin
				cfg_reg.fall <= wdat; // [R10]
			end
		end
	end

	// soft bit sticks until its pending flag is cleared; writing zero has no effect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_reg <= ELC_RST_ZERO; // [R16]
		end else begin
			soft_reg <= (soft_reg | (wr_soft ? wdat : ELC_RST_ZERO)) & ~(pend_clr & ~pend_next); // [R06]
		end
	end

	// pending has no documented reset; cleared here so it is never unknown
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_reg <= ELC_RST_ZERO;
		end else begin
			pend_reg <= pend_next; // [R20]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_irq   <= ELC_RST_ZERO;
			wake_event <= 1'b0;
		end else begin
			line_irq   <= pend_next & cfg_reg.imask; // [R21]
			wake_event <= |((edge_hit | soft_hit) & cfg_reg.emask); // [R03] [R04] [R22]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= ELC_RDATA_ZERO;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			prdata  <= ELC_RDATA_ZERO;
			if (psel && !penable && !pwrite) begin
				if (paddr == ELC_OFS_IMASK) begin
					prdata <= {14'h0000, cfg_reg.imask}; // [R14]
				end else if (paddr == ELC_OFS_EMASK) begin
					prdata <= {14'h0000, cfg_reg.emask};
				end else if (paddr == ELC_OFS_RISE) begin
					prdata <= {14'h0000, cfg_reg.rise};
				end else if (paddr == ELC_OFS_FALL) begin
					prdata <= {14'h0000, cfg_reg.fall};
				end else if (paddr == ELC_OFS_SOFT) begin
					prdata <= {14'h0000, soft_reg};
				end else if (paddr == ELC_OFS_PEND) begin
					prdata <= {14'h0000, pend_reg};
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/elc_asserts.sv
// port checker for the edge line controller
`timescale 1ns/1ps
`default_nettype none
module elc_asserts (
	input wire logic        pclk,     // clock
	input wire logic        presetn,  // reset
	input wire logic        psel,     // select
	input wire logic        penable,  // access
	input wire logic        pwrite,   // direction
	input wire logic [7:0]  paddr,    // address
	input wire logic [31:0] pwdata,   // wdata
	input wire logic [31:0] prdata,   // rdata
	input wire logic        pready,   // ready
	input wire logic        pslverr,  // error
	input wire logic [17:0] line_irq  // requests
);
	logic [17:0] imask_sh;
	wire         wr_acc = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow mask, written on the access edge like the design
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			imask_sh <= 18'h00000;
		else if (wr_acc && paddr == 8'h00)
			imask_sh <= pwdata[17:0];
	end
	ready_in_access_a: assert property (psel && penable |-> pready) else $error("no ready");
	ready_one_cycle_a: assert property (pready |-> psel && penable ##1 !pready) else $error("bad ready");
	rsvd_read_zero_a: assert property (pready && !pwrite |-> prdata[31:18] == 14'h0000) else $error("rsvd");
	idle_rdata_zero_a: assert property (!pready |-> prdata == 32'h00000000) else $error("rdata idle");
	slverr_map_a: assert property (pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'b00)) else $error("map");
	imask_read_a: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata == {14'h0000, imask_sh})
		else $error("mask read");
	irq_masked_a: assert property ((line_irq & ~imask_sh & ~$past(imask_sh)) == 18'h00000) else $error("mask");
	// a mask write lands one edge before the request register sees it
	irq_clear_why_a: assert property ((~line_irq & $past(line_irq)) != 18'h00000 |->
		$past(wr_acc && paddr == 8'h14) || $past(wr_acc && paddr == 8'h00, 2)) else $error("irq dropped");
endmodule
bind elc_top elc_asserts i_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .line_irq);
`default_nettype wire

//--- dv/elc_core_model.sv
// core wake logic model: counts wake-up pulses
`timescale 1ns/1ps
`default_nettype none
module elc_core_model (
	input  wire logic       pclk,       // clock
	input  wire logic       presetn,    // reset
	input  wire logic       wake_event, // pulse
	output logic      [7:0] wake_cnt    // wakes
);
	// each cycle high counts, so a stretched pulse shows as extra wakes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wake_cnt <= 8'h00;
		else if (wake_event)
			wake_cnt <= wake_cnt + 8'h01;
	end
endmodule
`default_nettype wire

//--- dv/edge_interrupt_event_controller_test.sv
// bench for the edge line controller
`timescale 1ns/1ps
`default_nettype none
module edge_interrupt_event_controller_test;
	import elc_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, wake_event, err;
	logic [7:0]  paddr = 8'h00, wake_cnt, cnt0;
	logic [31:0] pwdata = 32'h0, prdata, rd, bit_sel, pend;
	logic [17:0] lines = 18'h0, line_irq;
	int          err_total = 0, n_compared = 0;
	// irq, event, rise, fall, spare, line number
	logic [9:0]  rows [7] = '{10'h280, 10'h147, 10'h2D0, 10'h191, 10'h34F, 10'h3C5, 10'h209};
	elc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.gpio_lines(lines[15:0]), .voltage_detector_output(lines[16]), .rtc_alarm(lines[17]), .line_irq, .wake_event);
	elc_core_model i_core (.pclk, .presetn, .wake_event, .wake_cnt);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// entered just after an edge; leaves one idle edge after the access
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	initial begin
		forever #4 pclk = ~pclk;
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			bit_sel = 32'h1 << rows[i][4:0];
			apb(1'b1, ELC_OFS_IMASK, rows[i][9] ? bit_sel : 32'h0);
			apb(1'b1, ELC_OFS_EMASK, rows[i][8] ? bit_sel : 32'h0);
			apb(1'b1, ELC_OFS_RISE, rows[i][7] ? bit_sel : 32'h0);
			apb(1'b1, ELC_OFS_FALL, rows[i][6] ? bit_sel : 32'h0);
			cnt0 = wake_cnt;
			repeat (2) begin
				lines <= lines ^ bit_sel[17:0]; // clean full-cycle levels only
				repeat (8) @(posedge pclk);
			end
			pend = (rows[i][9] && rows[i][7:6] != 2'b00) ? bit_sel : 32'h0;
			check({14'h0, line_irq}, pend);
			check(32'(wake_cnt - cnt0), rows[i][8] ? 32'(rows[i][7]) + 32'(rows[i][6]) : 32'h0);
			apb(1'b0, ELC_OFS_PEND, 32'h0);
			check(rd, pend);
			apb(1'b1, ELC_OFS_PEND, bit_sel);
			check({14'h0, line_irq}, 32'h0);
			$display("row %0d done", i);
		end
		apb(1'b1, ELC_OFS_IMASK, 32'h00000200);
		apb(1'b1, ELC_OFS_EMASK, 32'h00000200);
		cnt0 = wake_cnt;
		apb(1'b1, ELC_OFS_SOFT, 32'h00000200);
		check({14'h0, line_irq}, 32'h00000200);
		@(posedge pclk);
		check(32'(wake_cnt - cnt0), 32'h1);
		apb(1'b0, ELC_OFS_SOFT, 32'h0);
		check(rd, 32'h00000200);
		apb(1'b1, ELC_OFS_PEND, 32'h00000200);
		apb(1'b0, ELC_OFS_SOFT, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, ELC_OFS_IMASK, 32'h00000008);
		apb(1'b1, ELC_OFS_RISE, 32'h00000008);
		lines <= 18'h00008;
		@(posedge pclk);
		// edge reaches the detector on the access edge of this write
		apb(1'b1, ELC_OFS_RISE, 32'h00000008);
		repeat (4) @(posedge pclk);
		check({14'h0, line_irq}, 32'h0);
		lines <= 18'h00000;
		repeat (8) @(posedge pclk);
		lines <= 18'h00008;
		repeat (8) @(posedge pclk);
		check({14'h0, line_irq}, 32'h00000008);
		apb(1'b1, ELC_OFS_PEND, 32'h00000008);
		lines <= 18'h00000;
		$display("select write collision done");
		apb(1'b0, 8'h18, 32'h0);
		check({rd[31:1], err}, 32'h1);
		$display("soft and unmapped done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 5; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0);
			check(rd, 32'h0);
		end
		$display("reset values done");
		finish_test();
	end
endmodule
`default_nettype wire
